// ### rtl/bsps_sequencer.sv
// Purpose: Start-up and protection sequencer for a synchronous buck stage
// Assumes: Comparator levels arrive unsynchronised; Wishbone classic slave
// Notes:   Switching period is a fixed division of clk_i; duty is set by software
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module bsps_sequencer
	import bsps_pkg::*;
#(
	parameter int PERIOD_CLKS     = SW_PERIOD_CLKS,
	parameter int HICCUP_CYCLES   = HICCUP_SW_CYCLES,
	parameter int PG_DELAY_CYCLES = PG_DELAY_SW_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Lockout comparators
	input  wire logic        vcc_ok_i,
	input  wire logic        enable_ok_i,
	// Sense comparators
	input  wire logic        oc_below_gnd_i,
	input  wire logic        ov_trip_i,
	input  wire logic        ov_release_i,
	input  wire logic        overtemp_i,
	input  wire logic        pg_window_i,
	input  wire logic        ss_low_i,
	input  wire logic        ss_above_pg_i,
	// Gate drivers
	output logic             hs_gate_o,
	output logic             ls_gate_o,
	output logic             drv_hiz_o,
	output logic             ss_discharge_o,
	// Power-good open drain
	output logic             pgood_o,
	output logic             pgood_oe_o,
	// Fault flags
	output logic             overcurrent_fault_o,
	output logic             overvoltage_fault_o
);
	localparam int PW = 8; // Phase and duty width

	if (PERIOD_CLKS < 2 * OC_BLANK_CYCLES || PERIOD_CLKS > 255)
	begin : g_bad_period
		$error("bsps_sequencer: PERIOD_CLKS out of range");
	end

	bsps_state_e  state;       // Sequencer state
	bsps_state_e  next_state;  // Next sequencer state
	logic [PW-1:0] phase;      // Position in switching period
	logic          sw_tick;    // Last clock of a period
	logic [PW-1:0] duty;       // High-side on-time from software
	logic [PW-1:0] duty_eff;   // Duty clamped below the period
	logic [PW-1:0] ls_full;    // Steady low-side width
	logic [PW-1:0] ls_width;   // Low-side width in use
	logic [2:0]    step;       // Quarter step, 1..4
	logic [5:0]    pulses;     // Pulses issued in this step
	logic          hs_seen;    // High-side pulse seen in pre-bias
	logic [PW-1:0] ls_on_cnt;  // Clocks since low-side turn-on
	logic          next_hs;    // Next high-side gate
	logic          next_ls;    // Next low-side gate
	logic          oc_hit;     // Qualified over-current sample
	logic          hiccup_done;
	logic          pg_qual;    // Power-good qualifiers all true
	logic          pg_done;
	logic          ready;      // Supply and enable both above lockout
	logic [8:0]    sy;         // Synchronised comparators

	// All comparators pass two flops first
	bsps_sync #(.W(9)) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i({vcc_ok_i, enable_ok_i, oc_below_gnd_i, ov_trip_i, ov_release_i,
			overtemp_i, pg_window_i, ss_low_i, ss_above_pg_i}),
		.sync_o (sy)
	);

	wire s_oc     = sy[6];
	wire s_ovtrip = sy[5];
	wire s_ovrel  = sy[4];
	wire s_hot    = sy[3];
	wire s_pgwin  = sy[2];
	wire s_sslow  = sy[1];
	wire s_sspg   = sy[0];

	assign ready = sy[8] & sy[7];

	// Width for a given quarter step of the steady low-side width
	function automatic logic [PW-1:0] quarter_width(input logic [PW-1:0] full,
		input logic [2:0] q);
		logic [PW+2:0] prod;
		prod = {3'b000, full} * {{PW{1'b0}}, q};
		return prod[PW+1:2];
	endfunction

	// Pulses in the group of a given step
	function automatic logic [5:0] group_len(input logic [2:0] q);
		unique case (q)
			3'd1:    return 6'(GROUP_Q1);
			3'd2:    return 6'(GROUP_Q2);
			default: return 6'(GROUP_Q3);
		endcase
	endfunction

	// Switching oscillator: free-running period counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i || sw_tick)
			phase <= '0;
		else
			phase <= phase + PW'(1);
	end

	assign sw_tick = (phase == PW'(PERIOD_CLKS - 1));

	// Duty must leave room for the low side
	assign duty_eff = (duty < PW'(PERIOD_CLKS - 1)) ? duty : PW'(PERIOD_CLKS - 1);
	assign ls_full  = PW'(PERIOD_CLKS) - duty_eff;
	assign ls_width = (state == SQ_RAMP) ? quarter_width(ls_full, step) : ls_full;

	// Gate pattern per state; low side sits at the end of the period
	always_comb
	begin
		next_hs = 1'b0;
		next_ls = 1'b0;
		unique case (state)
			SQ_PREBIAS:
				next_hs = (phase < duty_eff); // Low side kept off
			SQ_RAMP, SQ_RUN:
			begin
				next_hs = (phase < duty_eff);
				next_ls = (phase >= PW'(PERIOD_CLKS) - ls_width);
			end
			SQ_OVHOLD:
				next_ls = 1'b1; // Discharge output through low side
			default:
			begin
				next_hs = 1'b0; // Both off in every other state
				next_ls = 1'b0;
			end
		endcase
	end

	// Gate registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hs_gate_o <= 1'b0;
			ls_gate_o <= 1'b0;
		end
		else
		begin
			hs_gate_o <= next_hs;
			ls_gate_o <= next_ls;
		end
	end

	// Low-side on-time, gives the blanking window
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !ls_gate_o)
			ls_on_cnt <= '0;
		else if (ls_on_cnt != PW'(OC_BLANK_CYCLES))
			ls_on_cnt <= ls_on_cnt + PW'(1);
	end

	// Sample only after switching noise has settled
	assign oc_hit = ls_gate_o && (ls_on_cnt == PW'(OC_BLANK_CYCLES)) && s_oc;

	// Sequencer next state; lockout first, then over-voltage, heat, over-current, soft-start
	always_comb
	begin
		next_state = state;
		if (!ready)
			next_state = SQ_OFF;
		else
		begin
			unique case (state)
				SQ_OFF:
					next_state = SQ_PREBIAS;
				SQ_PREBIAS, SQ_RAMP, SQ_RUN:
				begin
					if (s_ovtrip)
						next_state = SQ_OVHOLD;
					else if (s_hot)
						next_state = SQ_THERMAL;
					else if (oc_hit)
						next_state = SQ_HICCUP; // Fires in ramp and run only; low side stays off in pre-bias
					else if (state != SQ_PREBIAS && s_sslow)
						next_state = SQ_SSOFF;
					else if (state == SQ_PREBIAS && sw_tick && hs_seen)
						next_state = SQ_RAMP;
					else if (state == SQ_RAMP && sw_tick && step == 3'd4)
						next_state = SQ_RUN;
				end
				SQ_HICCUP:
					if (hiccup_done)
						next_state = SQ_PREBIAS; // Retry; repeats while the fault stays
				SQ_THERMAL:
					if (!s_hot)
						next_state = SQ_PREBIAS;
				SQ_OVHOLD:
					if (s_ovrel)
						next_state = SQ_OVLATCH;
				SQ_OVLATCH:
					next_state = SQ_OVLATCH; // Only a lockout reaches OFF
				SQ_SSOFF:
					if (!s_sslow)
						next_state = SQ_PREBIAS;
				default:
					next_state = SQ_OFF;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= SQ_OFF;
		else
			state <= next_state;
	end

	// Pre-bias watch for the first high-side pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state != SQ_PREBIAS)
			hs_seen <= 1'b0;
		else if (hs_gate_o)
			hs_seen <= 1'b1;
	end

	// Step and pulse counting through the ramp
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state != SQ_RAMP)
		begin
			step   <= 3'd1;
			pulses <= '0;
		end
		else if (sw_tick && step != 3'd4)
		begin
			if (pulses == group_len(step) - 6'(1))
			begin
				step   <= step + 3'd1;
				pulses <= '0;
			end
			else
				pulses <= pulses + 6'(1);
		end
	end

	// Hiccup hold-off in switching cycles
	bsps_cycle_count #(.W(14), .LIMIT(HICCUP_CYCLES)) u_hiccup (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clear_i(state != SQ_HICCUP),
		.tick_i (sw_tick),
		.done_o (hiccup_done)
	);

	// Soft-start node held low while hiccup or heat shutdown
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ss_discharge_o <= 1'b1;
		else
			ss_discharge_o <= (next_state == SQ_HICCUP) || (next_state == SQ_THERMAL)
				|| (next_state == SQ_OFF);
	end

	// Drivers float only under lockout
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			drv_hiz_o <= 1'b1;
		else
			drv_hiz_o <= !ready;
	end

	// Over-current flag: set wins, cleared when hiccup ends
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			overcurrent_fault_o <= 1'b0;
		else if (oc_hit && (state == SQ_PREBIAS || state == SQ_RAMP || state == SQ_RUN))
			overcurrent_fault_o <= 1'b1;
		else if (state == SQ_HICCUP && hiccup_done)
			overcurrent_fault_o <= 1'b0;
	end

	// Over-voltage flag: held until supply or enable drops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			overvoltage_fault_o <= 1'b0;
		else if (next_state == SQ_OVHOLD)
			overvoltage_fault_o <= 1'b1;
		else if (!ready)
			overvoltage_fault_o <= 1'b0;
	end

	// Power-good qualifiers: window, soft-start level, ramp or run state
	assign pg_qual = s_pgwin && s_sspg && (state == SQ_RAMP || state == SQ_RUN);

	// Delay restarts whenever a qualifier drops
	bsps_cycle_count #(.W(10), .LIMIT(PG_DELAY_CYCLES)) u_pgdelay (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clear_i(!pg_qual),
		.tick_i (sw_tick),
		.done_o (pg_done)
	);

	// Open drain: pin always pulls low, enable released when good
	assign pgood_o = 1'b0;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pgood_oe_o <= 1'b1;
		else
			pgood_oe_o <= !(pg_done && pg_qual);
	end

	// Wishbone: one wait state, ack drops the cycle after it rose
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	// Duty register, low byte lane only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			duty <= DUTY_RESET;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
			&& wb_adr_i == REG_DUTY)
			duty <= wb_dat_i[7:0];
	end

	// Read data; unmapped addresses return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
		begin
			wb_dat_o <= '0;
			if (wb_adr_i == REG_DUTY)
				wb_dat_o[7:0] <= duty;
			else if (wb_adr_i == REG_STATUS)
			begin
				wb_dat_o[ST_STATE_LSB +: 9] <= state;
				wb_dat_o[ST_OC_BIT]         <= overcurrent_fault_o;
				wb_dat_o[ST_OV_BIT]         <= overvoltage_fault_o;
				wb_dat_o[ST_PG_BIT]         <= !pgood_oe_o;
				wb_dat_o[ST_READY_BIT]      <= ready;
				wb_dat_o[ST_HOT_BIT]        <= s_hot;
			end
		end
	end
endmodule

// ### rtl/bsps_pkg.sv
// Purpose: Shared constants for the buck start-up and protection sequencer
// Assumes: 50 MHz system clock, switching period derived in the top module
// Notes:   Register map, field positions, reset values and timing counts
package bsps_pkg;
	// System clock
	localparam int CLK_PERIOD_NS = 20;
	// Over-current blanking after low-side turn-on
	localparam int OC_BLANK_NS     = 160;
	localparam int OC_BLANK_CYCLES = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Counts in switching cycles
	localparam int HICCUP_SW_CYCLES = 4096;
	localparam int PG_DELAY_SW_CYCLES = 256;
	// Low-side start-up pulse groups at 25, 50 and 75 percent
	localparam int GROUP_Q1 = 32;
	localparam int GROUP_Q2 = 16;
	localparam int GROUP_Q3 = 8;
	// Default switching period in system clocks (500 kHz)
	localparam int SW_PERIOD_CLKS = 100;
	// Register byte addresses
	localparam logic [7:0] REG_DUTY   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// Duty register reset value, high-side on-time in clocks
	localparam logic [7:0] DUTY_RESET = 8'h24;
	// Status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_OC_BIT    = 9;
	localparam int ST_OV_BIT    = 10;
	localparam int ST_PG_BIT    = 11;
	localparam int ST_READY_BIT = 12;
	localparam int ST_HOT_BIT   = 13;
	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		SQ_OFF     = 9'h001,
		SQ_PREBIAS = 9'h002,
		SQ_RAMP    = 9'h004,
		SQ_RUN     = 9'h008,
		SQ_HICCUP  = 9'h010,
		SQ_THERMAL = 9'h020,
		SQ_OVHOLD  = 9'h040,
		SQ_OVLATCH = 9'h080,
		SQ_SSOFF   = 9'h100
	} bsps_state_e;
endpackage

// ### rtl/bsps_sync.sv
// Purpose: Two-flop synchroniser for a group of comparator levels
// Assumes: Inputs are slow levels, not pulses
// Notes:   Only the second stage may be used downstream
`timescale 1ns/100ps
module bsps_sync
	import bsps_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage1; // Metastability catcher, read only by stage two

	// Two stages, reset to low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage1 <= '0;
			sync_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

// ### rtl/bsps_cycle_count.sv
// Purpose: Saturating counter of switching-cycle ticks
// Assumes: tick_i is one clock wide, once per switching period
// Notes:   done_o holds high once LIMIT ticks were seen since the clear
`timescale 1ns/100ps
module bsps_cycle_count
	import bsps_pkg::*;
#(
	parameter int W     = 13,
	parameter int LIMIT = 4096
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic clear_i,
	input  wire logic tick_i,
	output logic      done_o
);
	logic [W-1:0] count; // Ticks seen so far

	if (LIMIT < 1 || LIMIT >= (1 << W))
	begin : g_bad_limit
		$error("bsps_cycle_count: LIMIT does not fit W");
	end

	assign done_o = (count == W'(LIMIT));

	// Restart on clear, stop at the limit
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i)
			count <= '0;
		else if (tick_i && !done_o)
			count <= count + W'(1);
	end
endmodule

// ### sim/bsps_checker.sv
// Purpose: Port checks for the buck sequencer
// Assumes: One clock; comparators pass two flops, outputs one more (gates two more)
// Notes:   Repetitions of four or five cover sync delay
`timescale 1ns/100ps
module bsps_checker
	import bsps_pkg::*;
#(
	parameter int PERIOD_CLKS   = 100,
	parameter int HICCUP_CYCLES = 4096
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched pins
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic vcc_ok_i,
	input wire logic enable_ok_i,
	input wire logic ov_trip_i,
	input wire logic overtemp_i,
	input wire logic pg_window_i,
	input wire logic hs_gate_o,
	input wire logic ls_gate_o,
	input wire logic drv_hiz_o,
	input wire logic ss_discharge_o,
	input wire logic pgood_o,
	input wire logic pgood_oe_o,
	input wire logic overcurrent_fault_o,
	input wire logic overvoltage_fault_o
);
	logic [15:0] ls_run; // Consecutive low-side on clocks
	logic [15:0] oc_run; // Clocks spent with the flag up
	// Run lengths; saturation not needed within one test
	always_ff @(posedge clk_i)
	begin
		ls_run <= ls_gate_o ? ls_run + 16'h0001 : 16'h0000;
		oc_run <= overcurrent_fault_o ? oc_run + 16'h0001 : 16'h0000;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_hot;
		(overtemp_i && !ov_trip_i && !overvoltage_fault_o) [*5];
	endsequence
	chk_ack_next_cycle: assert property (s_req |=> wb_ack_o) else $error("no ack one cycle after request");
	chk_lockout_hiz: assert property ((!enable_ok_i) [*4] |-> drv_hiz_o) else $error("drivers not tristated");
	// Gates lag the comparator by one more register (the state) than the tristate flag, so five samples are needed here
	chk_lockout_gates: assert property ((!vcc_ok_i) [*5] |-> !hs_gate_o && !ls_gate_o) else $error("gate in lockout");
	chk_ov_hold: assert property ($rose(overvoltage_fault_o) |=> !hs_gate_o && ls_gate_o) else $error("bad ov drive");
	chk_ov_latch_off: assert property (overvoltage_fault_o && $past(overvoltage_fault_o) |-> !hs_gate_o)
		else $error("high side on after ov");
	chk_oc_blanking: assert property ($rose(overcurrent_fault_o) |-> $past(ls_run) >= OC_BLANK_CYCLES - 2)
		else $error("oc inside blanking");
	chk_hiccup_span: assert property ($fell(overcurrent_fault_o) |-> oc_run >= (HICCUP_CYCLES - 1) * PERIOD_CLKS
		&& oc_run <= (HICCUP_CYCLES + 1) * PERIOD_CLKS) else $error("hiccup length wrong");
	chk_hiccup_off: assert property (overcurrent_fault_o && $past(overcurrent_fault_o, 2)
		|-> !hs_gate_o && !ls_gate_o && ss_discharge_o) else $error("gates active in hiccup");
	chk_hot_off: assert property (s_hot |-> !hs_gate_o && !ls_gate_o && ss_discharge_o)
		else $error("gates active when hot");
	chk_pg_open_drain: assert property (!pgood_o) else $error("power good driven high");
	chk_pg_window: assert property ((!pg_window_i) [*4] |-> pgood_oe_o) else $error("good outside window");
endmodule

bind bsps_sequencer bsps_checker #(.PERIOD_CLKS(PERIOD_CLKS), .HICCUP_CYCLES(HICCUP_CYCLES)) u_chk (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .vcc_ok_i, .enable_ok_i, .ov_trip_i, .overtemp_i, .pg_window_i, .hs_gate_o,
	.ls_gate_o, .drv_hiz_o, .ss_discharge_o, .pgood_o, .pgood_oe_o, .overcurrent_fault_o, .overvoltage_fault_o);

// ### sim/bsps_stage_model.sv
// Purpose: Power stage and sense comparators beside the sequencer
// Assumes: Soft-start node charges one step a clock, scaled
// Notes:   Overload, node pull and window fault are bench commands
`timescale 1ns/100ps
module bsps_stage_model
(
	// Clock and stage commands
	input  wire logic clk_i,
	input  wire logic ls_gate_i,
	input  wire logic ss_discharge_i,
	// Bench commands
	input  wire logic overload_i,
	input  wire logic ss_pull_i,
	input  wire logic pg_bad_i,
	// Comparators
	output logic      oc_below_gnd_o,
	output logic      ss_low_o,
	output logic      ss_above_pg_o,
	output logic      pg_window_o
);
	logic [5:0] ss_lvl; // Soft-start node level
	// Node charges up unless shorted by the device or pulled by the bench
	always_ff @(posedge clk_i)
	begin
		if (ss_discharge_i || ss_pull_i)
			ss_lvl <= 6'h00;
		else if (ss_lvl != 6'h3f)
			ss_lvl <= ss_lvl + 6'h01;
	end
	// Sense node only goes negative while the low side conducts
	assign oc_below_gnd_o = overload_i && ls_gate_i;
	assign ss_low_o = ss_lvl < 6'h04;
	assign ss_above_pg_o = ss_lvl > 6'h28;
	assign pg_window_o = ss_lvl > 6'h14 && !pg_bad_i;
endmodule

// ### sim/tb.sv
// Purpose: Self-checking bench for the buck sequencer
// Assumes: Short period and counts set by parameters
// Notes:   Overload, node pull and window faults go through the stage model; heat and over-voltage are driven directly
`timescale 1ns/100ps
module tb
	import bsps_pkg::*;
;
	localparam int P = 20; // Switching period in clocks
	localparam int D = 8;  // High-side on-time
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0]  wb_sel_i;
	logic        vcc_ok_i, enable_ok_i, ov_trip_i, ov_release_i, overtemp_i, overload, ss_pull, pg_bad;
	logic        oc_below_gnd_i, pg_window_i, ss_low_i, ss_above_pg_i, hs_gate_o, ls_gate_o, drv_hiz_o;
	logic        ss_discharge_o, pgood_o, pgood_oe_o, overcurrent_fault_o, overvoltage_fault_o, seen_hs, oc_prev;
	int          miscompares, comparisons, ls_w, oc_rises, n;
	int          widths[$]; // Low-side pulse widths
	bsps_sequencer #(.PERIOD_CLKS(P), .HICCUP_CYCLES(4), .PG_DELAY_CYCLES(4)) dut (.*);
	bsps_stage_model u_stage (.clk_i(clk_i), .ls_gate_i(ls_gate_o), .ss_discharge_i(ss_discharge_o),
		.overload_i(overload), .ss_pull_i(ss_pull), .pg_bad_i(pg_bad), .oc_below_gnd_o(oc_below_gnd_i),
		.ss_low_o(ss_low_i), .ss_above_pg_o(ss_above_pg_i), .pg_window_o(pg_window_i));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Classic single cycle; held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check(32'(k < 20), 32'h1);
	endtask
	task automatic wait_hs(input int lim);
		n = 0;
		while (hs_gate_o !== 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		check(32'(hs_gate_o), 32'h1);
	endtask
	// Poll the state field until steady running
	task automatic to_run;
		n = 0;
		do
		begin
			repeat (50) @(posedge clk_i);
			wb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rd[8:0] !== SQ_RUN && n < 60);
		check(32'(rd[8:0]), 32'(SQ_RUN));
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Pulse widths, pre-bias order and over-current retries
	always @(posedge clk_i)
	begin
		ls_w <= ls_gate_o ? ls_w + 1 : 0;
		if (!ls_gate_o && ls_w != 0)
			widths.push_back(ls_w);
		seen_hs <= (ss_discharge_o || drv_hiz_o) ? 1'b0 : seen_hs || hs_gate_o;
		if (ls_gate_o && !seen_hs)
			check(32'(ls_gate_o), 32'h0);
		oc_prev <= overcurrent_fault_o;
		if (overcurrent_fault_o && !oc_prev)
			oc_rises++;
	end
	initial
	begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		{rst_i, wb_sel_i} = 5'h1f;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{vcc_ok_i, enable_ok_i, ov_trip_i, overtemp_i, overload, ss_pull, pg_bad} = '0;
		{ov_release_i, seen_hs, oc_prev, ls_w, oc_rises} = '0;
		ov_release_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_DUTY, 32'h0);
		check(rd, 32'(DUTY_RESET));
		wb(1'b1, REG_DUTY, 32'(D));
		wb(1'b1, 8'h10, 32'hffffffff);
		wb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, REG_DUTY, 32'h0);
		check(rd, 32'(D));
		wb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'(SQ_OFF));
		check(32'(drv_hiz_o), 32'h1);
		vcc_ok_i <= 1'b1;
		enable_ok_i <= 1'b1;
		widths.delete();
		to_run();
		for (int i = 0; i < 57; i++)
			check(32'(widths[i]), 32'((P - D) * (i < 32 ? 1 : i < 48 ? 2 : i < 56 ? 3 : 4) / 4));
		pg_bad <= 1'b1;
		repeat (5) @(posedge clk_i);
		check(32'(pgood_oe_o), 32'h1);
		pg_bad <= 1'b0;
		n = 0;
		while (pgood_oe_o !== 1'b0 && n < 500)
		begin
			@(posedge clk_i);
			n++;
		end
		check(32'(n >= 3 * P && n <= 5 * P + 4), 32'h1);
		oc_rises = 0;
		overload <= 1'b1;
		repeat (2 * P) @(posedge clk_i);
		wb(1'b0, REG_STATUS, 32'h0);
		check(rd & 32'h3ff, 32'h210);
		repeat (3000) @(posedge clk_i);
		check(32'(oc_rises >= 3), 32'h1);
		overload <= 1'b0;
		to_run();
		overtemp_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		check(32'({hs_gate_o, ls_gate_o, ss_discharge_o}), 32'h1);
		overtemp_i <= 1'b0;
		wait_hs(200);
		to_run();
		ss_pull <= 1'b1;
		// Node model adds one register ahead of the two sync flops
		repeat (8) @(posedge clk_i);
		check(32'({hs_gate_o, ls_gate_o}), 32'h0);
		ss_pull <= 1'b0;
		wait_hs(200);
		{ov_trip_i, ov_release_i} <= 2'h2;
		repeat (5) @(posedge clk_i);
		check(32'({hs_gate_o, ls_gate_o, overvoltage_fault_o}), 32'h3);
		{ov_trip_i, ov_release_i} <= 2'h1;
		repeat (300) @(posedge clk_i);
		check(32'({hs_gate_o, ls_gate_o, overvoltage_fault_o}), 32'h1);
		enable_ok_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		check(32'({drv_hiz_o, overvoltage_fault_o}), 32'h2);
		enable_ok_i <= 1'b1;
		wait_hs(200);
		tally_and_finish();
	end
endmodule
